// ### dac_cfg_pkg.sv
// Constants for the device configuration register bank: offsets,
// field positions, writable masks and reset values.
// Assumes an 8-bit register access port from the serial control engine.
package dac_cfg_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int PTR_W   = 8;

  typedef logic [ADDR_W-1:0] reg_addr_t;
  typedef logic [DATA_W-1:0] reg_data_t;
  typedef logic [PTR_W-1:0]  ptr_diff_t;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam reg_addr_t OFS_SERIAL_PORT_CONFIG     = 8'h00;
  localparam reg_addr_t OFS_POWER_DOWN_CONTROL     = 8'h01;
  localparam reg_addr_t OFS_INPUT_DATA_FORMAT      = 8'h03;
  localparam reg_addr_t OFS_EVENT_INTERRUPT_ENABLE = 8'h04;
  localparam reg_addr_t OFS_EVENT_FLAG             = 8'h06;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_SDIO_BIDIR     = 7;
  localparam int BIT_LSB_FIRST      = 6;
  localparam int BIT_SOFT_RESET     = 5;

  localparam int BIT_PD_I_DAC       = 7;
  localparam int BIT_PD_Q_DAC       = 6;
  localparam int BIT_PD_RECEIVER    = 5;
  localparam int BIT_PD_AUX_ADC     = 4;

  localparam int BIT_BINARY_FORMAT  = 7;
  localparam int BIT_Q_FIRST        = 6;
  localparam int BIT_MSB_SWAP       = 5;
  localparam int BIT_BUS_WIDTH_LO   = 0;
  localparam int BIT_BUS_WIDTH_HI   = 1;

  localparam int BIT_PLL_LOCK_LOST  = 7;
  localparam int BIT_PLL_LOCKED     = 6;
  localparam int BIT_SYNC_LOST      = 5;
  localparam int BIT_SYNC_LOCKED    = 4;
  localparam int BIT_FIFO_WARN_1    = 1;
  localparam int BIT_FIFO_WARN_2    = 0;

  // ****************************************************************
  // Bus width codes
  // ****************************************************************
  localparam logic [1:0] WIDTH_WORD    = 2'h0;
  localparam logic [1:0] WIDTH_BYTE    = 2'h1;
  localparam logic [1:0] WIDTH_NIBBLE  = 2'h2;
  localparam logic [1:0] WIDTH_INVALID = 2'h3;

  // FIFO pointer distances that raise the two warnings
  localparam ptr_diff_t FIFO_WARN_1_DIFF = 8'h01;
  localparam ptr_diff_t FIFO_WARN_2_DIFF = 8'h02;

  // ****************************************************************
  // Writable masks and reset values
  // ****************************************************************
  localparam reg_data_t MASK_SERIAL_PORT_CONFIG  = 8'he0;
  localparam reg_data_t MASK_POWER_DOWN_CONTROL  = 8'hf0;
  localparam reg_data_t MASK_INPUT_DATA_FORMAT   = 8'he3;
  localparam reg_data_t MASK_EVENT_BITS          = 8'hf3;

  localparam reg_data_t RST_SERIAL_PORT_CONFIG   = 8'h00;
  localparam reg_data_t RST_POWER_DOWN_CONTROL   = 8'h10;
  localparam reg_data_t RST_INPUT_DATA_FORMAT    = 8'h00;
  localparam reg_data_t RST_EVENT_INTERRUPT_EN   = 8'h00;
  localparam reg_data_t RST_EVENT_FLAG           = 8'h00;

endpackage : dac_cfg_pkg

// ### dac_device_config_regs.sv
// Device configuration register bank with event flags and interrupt.
// Assumes the serial control engine presents one register access per
// strobe on clk, and that event inputs come from logic on clk.
`timescale 1ns/1ps

//Contract
// - Serial config bit 7 selects bidirectional data pin
// - Serial config bit 6 selects LSB first
// - Serial config bit 5 holds device reset
// - Power bits 7,6 power down I,Q
// - Power bit 5 powers down data receiver
// - Power bit 4 powers down aux ADC, resets one
// - Format bit 7 selects straight binary samples
// - Format bit 6 selects Q sample first
// - Format bit 5 reverses input bit order
// - Format bits 1:0 set bus width; 11 invalid
// - Enable bits 7,6 for PLL lost/locked
// - Enable bits 5,4 for sync lost/locked
// - Enable bits 1,0 for FIFO warnings
// - Event flags cleared by writing one
// - FIFO warnings at pointer distance 1, 2
module dac_device_config_regs (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register access port from the serial engine
  input  wire dac_cfg_pkg::reg_addr_t reg_addr,
  input  wire logic                   reg_wr,
  input  wire dac_cfg_pkg::reg_data_t reg_wdata,
  input  wire logic                   reg_rd,
  output logic                        reg_rvalid,
  output dac_cfg_pkg::reg_data_t      reg_rdata,
  // Events from the datapath
  input  wire logic                   pll_lock_lost_ev,
  input  wire logic                   pll_locked_ev,
  input  wire logic                   sync_lost_ev,
  input  wire logic                   sync_locked_ev,
  input  wire dac_cfg_pkg::ptr_diff_t fifo_ptr_diff,
  // Serial port controls
  output logic                        sdio_bidir,
  output logic                        lsb_first,
  output logic                        soft_reset,
  // Power controls
  output logic                        pd_i_dac,
  output logic                        pd_q_dac,
  output logic                        pd_receiver,
  output logic                        pd_aux_adc,
  // Data format controls
  output logic                        binary_format,
  output logic                        q_first,
  output logic                        msb_swap,
  output logic [1:0]                  bus_width,
  output logic                        bus_width_invalid,
  // Interrupt
  output logic                        irq
);
  import dac_cfg_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    hit = (a == ofs);
  endfunction

  reg_data_t serial_port_config_r;
  reg_data_t power_down_control_r;
  reg_data_t input_data_format_r;
  reg_data_t event_interrupt_enable_r;
  reg_data_t event_flag_r;

  wire logic wr_serial = reg_wr & hit(reg_addr, OFS_SERIAL_PORT_CONFIG);
  wire logic wr_power  = reg_wr & hit(reg_addr, OFS_POWER_DOWN_CONTROL);
  wire logic wr_format = reg_wr & hit(reg_addr, OFS_INPUT_DATA_FORMAT);
  wire logic wr_enable = reg_wr & hit(reg_addr, OFS_EVENT_INTERRUPT_ENABLE);
  wire logic wr_flag   = reg_wr & hit(reg_addr, OFS_EVENT_FLAG);

  // Only defined bits are stored; the rest stay zero
  wire reg_data_t serial_nxt = reg_wdata & MASK_SERIAL_PORT_CONFIG;
  wire reg_data_t power_nxt  = reg_wdata & MASK_POWER_DOWN_CONTROL;
  wire reg_data_t format_nxt = reg_wdata & MASK_INPUT_DATA_FORMAT;
  wire reg_data_t enable_nxt = reg_wdata & MASK_EVENT_BITS;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // The soft reset bit does not clear this bank: software must be able
  // to write it low again to leave reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_port_config_r     <= RST_SERIAL_PORT_CONFIG;
      power_down_control_r     <= RST_POWER_DOWN_CONTROL;
      input_data_format_r      <= RST_INPUT_DATA_FORMAT;
      event_interrupt_enable_r <= RST_EVENT_INTERRUPT_EN;
    end else begin
      if (wr_serial) serial_port_config_r <= serial_nxt;
      if (wr_power)  power_down_control_r <= power_nxt;
      if (wr_format) input_data_format_r <= format_nxt;
      if (wr_enable) event_interrupt_enable_r <= enable_nxt;
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  wire logic fifo_warn_1 = (fifo_ptr_diff == FIFO_WARN_1_DIFF);
  wire logic fifo_warn_2 = (fifo_ptr_diff == FIFO_WARN_2_DIFF);

  reg_data_t flag_set;
  always_comb begin
    flag_set                    = '0;
    flag_set[BIT_PLL_LOCK_LOST] = pll_lock_lost_ev;
    flag_set[BIT_PLL_LOCKED]    = pll_locked_ev;
    flag_set[BIT_SYNC_LOST]     = sync_lost_ev;
    flag_set[BIT_SYNC_LOCKED]   = sync_locked_ev;
    flag_set[BIT_FIFO_WARN_1]   = fifo_warn_1;
    flag_set[BIT_FIFO_WARN_2]   = fifo_warn_2;
  end

  wire reg_data_t flag_clr = wr_flag ? reg_wdata : '0;

  // A new event in the clearing cycle survives the clear
  wire reg_data_t flag_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_flag
      if (MASK_EVENT_BITS[gi]) begin : g_used
        assign flag_nxt[gi] = flag_set[gi] | (event_flag_r[gi] & ~flag_clr[gi]);
      end else begin : g_rsvd
        assign flag_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // One flop process for the whole flag word keeps a single driver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) event_flag_r <= RST_EVENT_FLAG;
    else     event_flag_r <= flag_nxt;
  end

  wire logic irq_nxt = |(event_flag_r & event_interrupt_enable_r);

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg_data_t rdata_nxt;
  always_comb begin
    rdata_nxt = '0;
    if (hit(reg_addr, OFS_SERIAL_PORT_CONFIG))     rdata_nxt = serial_port_config_r;
    if (hit(reg_addr, OFS_POWER_DOWN_CONTROL))     rdata_nxt = power_down_control_r;
    if (hit(reg_addr, OFS_INPUT_DATA_FORMAT))      rdata_nxt = input_data_format_r;
    if (hit(reg_addr, OFS_EVENT_INTERRUPT_ENABLE)) rdata_nxt = event_interrupt_enable_r;
    if (hit(reg_addr, OFS_EVENT_FLAG))             rdata_nxt = event_flag_r;
  end

  // ****************************************************************
  // Output flops
  // ****************************************************************
  // Controls are registered once more so every output leaves a flop
  // directly; they lag the write by one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rvalid        <= 1'b0;
      reg_rdata         <= '0;
      sdio_bidir        <= RST_SERIAL_PORT_CONFIG[BIT_SDIO_BIDIR];
      lsb_first         <= RST_SERIAL_PORT_CONFIG[BIT_LSB_FIRST];
      soft_reset        <= RST_SERIAL_PORT_CONFIG[BIT_SOFT_RESET];
      pd_i_dac          <= RST_POWER_DOWN_CONTROL[BIT_PD_I_DAC];
      pd_q_dac          <= RST_POWER_DOWN_CONTROL[BIT_PD_Q_DAC];
      pd_receiver       <= RST_POWER_DOWN_CONTROL[BIT_PD_RECEIVER];
      pd_aux_adc        <= RST_POWER_DOWN_CONTROL[BIT_PD_AUX_ADC];
      binary_format     <= RST_INPUT_DATA_FORMAT[BIT_BINARY_FORMAT];
      q_first           <= RST_INPUT_DATA_FORMAT[BIT_Q_FIRST];
      msb_swap          <= RST_INPUT_DATA_FORMAT[BIT_MSB_SWAP];
      bus_width         <= WIDTH_WORD;
      bus_width_invalid <= 1'b0;
      irq               <= 1'b0;
    end else begin
      reg_rvalid        <= reg_rd;
      reg_rdata         <= reg_rd ? rdata_nxt : '0;
      sdio_bidir        <= serial_port_config_r[BIT_SDIO_BIDIR];
      lsb_first         <= serial_port_config_r[BIT_LSB_FIRST];
      soft_reset        <= serial_port_config_r[BIT_SOFT_RESET];
      pd_i_dac          <= power_down_control_r[BIT_PD_I_DAC];
      pd_q_dac          <= power_down_control_r[BIT_PD_Q_DAC];
      pd_receiver       <= power_down_control_r[BIT_PD_RECEIVER];
      pd_aux_adc        <= power_down_control_r[BIT_PD_AUX_ADC];
      binary_format     <= input_data_format_r[BIT_BINARY_FORMAT];
      q_first           <= input_data_format_r[BIT_Q_FIRST];
      msb_swap          <= input_data_format_r[BIT_MSB_SWAP];
      bus_width         <= input_data_format_r[BIT_BUS_WIDTH_HI:BIT_BUS_WIDTH_LO];
      bus_width_invalid <= (input_data_format_r[BIT_BUS_WIDTH_HI:BIT_BUS_WIDTH_LO]
                            == WIDTH_INVALID);
      irq               <= irq_nxt;
    end
  end

endmodule // dac_device_config_regs

// ### dac_cfg_checker.sv
// Checker for the configuration register bank, bound to its ports.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ps
module dac_cfg_checker (
  // Clock, reset and register port
  input wire logic clk, rst, reg_wr, reg_rd, reg_rvalid,
  input wire dac_cfg_pkg::reg_addr_t reg_addr,
  input wire dac_cfg_pkg::reg_data_t reg_wdata, reg_rdata,
  // Events and controls
  input wire logic pll_lock_lost_ev, pll_locked_ev, sync_lost_ev, sync_locked_ev,
  input wire dac_cfg_pkg::ptr_diff_t fifo_ptr_diff,
  input wire logic sdio_bidir, lsb_first, soft_reset, pd_i_dac, pd_q_dac,
  input wire logic pd_receiver, pd_aux_adc, binary_format, q_first, msb_swap,
  input wire logic [1:0] bus_width,
  input wire logic bus_width_invalid, irq
);
  import dac_cfg_pkg::*;
  reg_data_t en_r;
  reg_data_t ev_vec;
  assign ev_vec = {pll_lock_lost_ev, pll_locked_ev, sync_lost_ev, sync_locked_ev, 2'b00,
                   fifo_ptr_diff == FIFO_WARN_1_DIFF, fifo_ptr_diff == FIFO_WARN_2_DIFF};
  // Mirror of the enable register, so irq can be judged without its body
  always_ff @(posedge clk or posedge rst) begin
    if (rst) en_r <= 8'h00;
    else if (reg_wr && reg_addr == OFS_EVENT_INTERRUPT_ENABLE) en_r <= reg_wdata;
  end
  function automatic reg_data_t rd_mask(input reg_addr_t a);
    case (a)
      OFS_SERIAL_PORT_CONFIG: return MASK_SERIAL_PORT_CONFIG;
      OFS_POWER_DOWN_CONTROL: return MASK_POWER_DOWN_CONTROL;
      OFS_INPUT_DATA_FORMAT:  return MASK_INPUT_DATA_FORMAT;
      OFS_EVENT_INTERRUPT_ENABLE, OFS_EVENT_FLAG: return MASK_EVENT_BITS;
      default: return 8'h00;
    endcase
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  serial_copy_a: assert property (reg_wr && reg_addr == OFS_SERIAL_PORT_CONFIG |->
    ##2 {sdio_bidir, lsb_first, soft_reset} == $past(reg_wdata[7:5], 2)) else $error("serial bits");
  power_copy_a: assert property (reg_wr && reg_addr == OFS_POWER_DOWN_CONTROL |->
    ##2 {pd_i_dac, pd_q_dac, pd_receiver, pd_aux_adc} == $past(reg_wdata[7:4], 2))
    else $error("power bits");
  format_copy_a: assert property (reg_wr && reg_addr == OFS_INPUT_DATA_FORMAT |->
    ##2 {binary_format, q_first, msb_swap, bus_width} == $past({reg_wdata[7:5], reg_wdata[1:0]}, 2))
    else $error("format bits");
  width_flag_a: assert property (bus_width_invalid == (bus_width == 2'h3))
    else $error("invalid width flag");
  read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  idle_data_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00) else $error("stray rdata");
  reserved_zero_a: assert property (reg_rd |=> (reg_rdata & ~rd_mask($past(reg_addr))) == 8'h00)
    else $error("reserved bit set");
  irq_masked_a: assert property ((en_r & MASK_EVENT_BITS) == 8'h00 |=> !irq)
    else $error("irq while masked");
  irq_raise_a: assert property ((ev_vec & en_r) != 8'h00 |-> ##[1:3] irq)
    else $error("irq missing");
  flag_clear_c: cover property (reg_wr && reg_addr == OFS_EVENT_FLAG);
  irq_c: cover property (irq);
  bad_width_c: cover property (bus_width_invalid);
endmodule // dac_cfg_checker

bind dac_device_config_regs dac_cfg_checker u_dac_cfg_checker (.clk, .rst, .reg_wr, .reg_rd,
  .reg_rvalid, .reg_addr, .reg_wdata, .reg_rdata, .pll_lock_lost_ev, .pll_locked_ev,
  .sync_lost_ev, .sync_locked_ev, .fifo_ptr_diff, .sdio_bidir, .lsb_first, .soft_reset,
  .pd_i_dac, .pd_q_dac, .pd_receiver, .pd_aux_adc, .binary_format, .q_first, .msb_swap,
  .bus_width, .bus_width_invalid, .irq);

// ### host_model.sv
// Host side of the register port: one strobe per access.
// Assumes the bank answers a read exactly one edge after the strobe.
`timescale 1ns/1ps
module host_model (
  // Clock and answer
  input  wire logic                   clk,
  input  wire logic                   reg_rvalid,
  input  wire dac_cfg_pkg::reg_data_t reg_rdata,
  // Requests
  output dac_cfg_pkg::reg_addr_t      reg_addr,
  output logic                        reg_wr,
  output dac_cfg_pkg::reg_data_t      reg_wdata,
  output logic                        reg_rd
);
  import dac_cfg_pkg::*;
  initial begin
    reg_addr = 8'h55;
    reg_wdata = 8'haa;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle address and data flip, so nothing relies on a stale value
  task automatic xfer(input logic w, input reg_addr_t a, input reg_data_t d, output reg_data_t q);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    q = 8'h00;
    if (!w) begin
      @(posedge clk);
      q = reg_rvalid ? reg_rdata : 8'hxx;
    end
  endtask
endmodule // host_model

// ### test_dac_device_config_regs.sv
// Testbench for the configuration register bank.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module test_dac_device_config_regs;
  import dac_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ev = 4'h0;
  ptr_diff_t fifo_ptr_diff = 8'h00;
  reg_addr_t reg_addr;
  reg_data_t reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, reg_rvalid, irq, bus_width_invalid, sdio_bidir, lsb_first, soft_reset;
  logic binary_format, q_first, msb_swap, pd_i_dac, pd_q_dac, pd_receiver, pd_aux_adc;
  logic [1:0] bus_width;
  int errors = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  dac_device_config_regs u_dac_device_config_regs (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rvalid, .reg_rdata, .pll_lock_lost_ev(ev[3]), .pll_locked_ev(ev[2]),
    .sync_lost_ev(ev[1]), .sync_locked_ev(ev[0]), .fifo_ptr_diff, .sdio_bidir, .lsb_first,
    .soft_reset, .pd_i_dac, .pd_q_dac, .pd_receiver, .pd_aux_adc, .binary_format, .q_first,
    .msb_swap, .bus_width, .bus_width_invalid, .irq);
  host_model u_host_model (.clk, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input reg_addr_t a, input reg_data_t exp);
    u_host_model.xfer(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  // Controls lag the register by one edge, hence the two extra edges
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    u_host_model.xfer(1'b1, a, d, q);
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] e, input ptr_diff_t p);
    @(posedge clk);
    ev <= e;
    fifo_ptr_diff <= p;
    @(posedge clk);
    ev <= 4'h0;
    fifo_ptr_diff <= 8'h03;
    repeat (3) @(posedge clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    check({pd_aux_adc, pd_i_dac, soft_reset, irq, bus_width, sdio_bidir}, 8'h40);
    rst <= 1'b0;
  endtask
  task automatic t_reset();
    rd_chk(OFS_SERIAL_PORT_CONFIG, 8'h00);
    rd_chk(OFS_POWER_DOWN_CONTROL, 8'h10);
    rd_chk(OFS_INPUT_DATA_FORMAT, 8'h00);
    rd_chk(OFS_EVENT_INTERRUPT_ENABLE, 8'h00);
    $display("done reset values");
  endtask
  task automatic t_serial_power();
    wr(8'h02, 8'hff);
    rd_chk(8'h02, 8'h00);
    wr(OFS_SERIAL_PORT_CONFIG, 8'hff);
    rd_chk(OFS_SERIAL_PORT_CONFIG, 8'he0);
    check({sdio_bidir, lsb_first, soft_reset}, 8'h07);
    wr(OFS_SERIAL_PORT_CONFIG, 8'h20);
    wr(OFS_POWER_DOWN_CONTROL, 8'h0f);
    rd_chk(OFS_POWER_DOWN_CONTROL, 8'h00);
    check({pd_i_dac, pd_q_dac, pd_receiver, pd_aux_adc, soft_reset}, 8'h01);
    wr(OFS_POWER_DOWN_CONTROL, 8'ha5);
    check({pd_i_dac, pd_q_dac, pd_receiver, pd_aux_adc, soft_reset}, 8'h15);
    wr(OFS_SERIAL_PORT_CONFIG, 8'h40);
    check({sdio_bidir, lsb_first, soft_reset}, 8'h02);
    $display("done serial and power");
  endtask
  task automatic t_format();
    reg_data_t d;
    // Code 3 is written on purpose to see the invalid-width flag
    for (int k = 0; k < 4; k++) begin
      d = {k[0], k[1], ~k[0], 3'b111, k[1:0]};
      wr(OFS_INPUT_DATA_FORMAT, d);
      rd_chk(OFS_INPUT_DATA_FORMAT, d & 8'he3);
      check({binary_format, q_first, msb_swap, bus_width, bus_width_invalid},
            {d[7:5], d[1:0], k == 3});
    end
    $display("done format");
  endtask
  task automatic t_events();
    wr(OFS_EVENT_INTERRUPT_ENABLE, 8'hff);
    rd_chk(OFS_EVENT_INTERRUPT_ENABLE, 8'hf3);
    for (int i = 0; i < 6; i++) begin
      pulse(i < 4 ? 4'h8 >> i : 4'h0, i < 4 ? 8'h00 : 8'(i - 3));
      check(irq, 1'b1);
      rd_chk(OFS_EVENT_FLAG, i < 4 ? 8'h80 >> i : 8'h02 >> (i - 4));
      wr(OFS_EVENT_FLAG, 8'hff);
      rd_chk(OFS_EVENT_FLAG, 8'h00);
      check(irq, 1'b0);
    end
    wr(OFS_EVENT_INTERRUPT_ENABLE, 8'h00);
    pulse(4'h4, 8'h00);
    check(irq, 1'b0);
    wr(OFS_EVENT_INTERRUPT_ENABLE, 8'h40);
    check(irq, 1'b1);
    $display("done events");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    do_reset();
    t_reset();
    t_serial_power();
    t_format();
    do_reset();
    t_events();
    give_verdict();
  end
  initial begin
    #40000;
    errors++;
    give_verdict();
  end
endmodule // test_dac_device_config_regs
